// ### sgd_pkg.sv
/*
  constants for the gate drive sequencer: register map, field positions,
  reset values, states and timing counts.
  assumes a 20 MHz core clock.
*/
package sgd_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int DRIVE_WINDOW_TIME_NS = 4000;
  localparam int DIGITAL_DEAD_TIME_NS = 100;
  localparam int OVERCURRENT_DEGLITCH_TIME_NS = 4000;
  localparam int INPUT_DEGLITCH_TIME_NS = 200;
  localparam int RETRY_TIME_NS = 4000000;
  // fixed windows round down, least times round up
  localparam int DRIVE_WINDOW_CYC = DRIVE_WINDOW_TIME_NS / CLK_PERIOD_NS;
  localparam int DEAD_CYC = (DIGITAL_DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCP_DEG_CYC = OVERCURRENT_DEGLITCH_TIME_NS / CLK_PERIOD_NS;
  localparam int IN_DEG_CYC = (INPUT_DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_CYC = RETRY_TIME_NS / CLK_PERIOD_NS;

  localparam int WIN_W = 8;
  localparam int DEG_W = 4;
  localparam int RETRY_W = 24;
  localparam logic [WIN_W-1:0] WIN_LOAD = WIN_W'(DRIVE_WINDOW_CYC);
  localparam logic [WIN_W-1:0] DEAD_LOAD = WIN_W'(DEAD_CYC);
  localparam logic [WIN_W-1:0] OCP_LIMIT = WIN_W'(OCP_DEG_CYC);
  localparam logic [DEG_W-1:0] IN_DEG_LIMIT = DEG_W'(IN_DEG_CYC);
  localparam logic [WIN_W-1:0] WIN_ONE = 8'h01;

  ////////////////////////////////////////////////////////////////////////////
  // register map (byte addresses)
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_CLEAR = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h8;

  // control fields
  localparam int CTRL_ISEL_LSB = 0;
  localparam int CTRL_TRIP_LSB = 4;
  localparam int CTRL_EN_BIT = 8;
  localparam int SEL_W = 3;
  localparam logic [SEL_W-1:0] SEL_MAX = 3'h6;
  localparam logic [SEL_W-1:0] ISEL_RESET = 3'h0;
  localparam logic [SEL_W-1:0] TRIP_RESET = 3'h0;
  localparam logic EN_RESET = 1'b0;

  // clear fields
  localparam int CLR_GDF_BIT = 0;

  // status fields
  localparam int ST_GDF_BIT = 0;
  localparam int ST_OCP_BIT = 1;
  localparam int ST_CPUV_BIT = 2;
  localparam int ST_REGUV_BIT = 3;
  localparam int ST_PIN_BIT = 4;
  localparam int ST_HI_LSB = 8;
  localparam int ST_LO_LSB = 12;
  localparam int ST_OCPSRC_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // per half-bridge sequencer states, gray along hold-off-dead-on
  typedef enum logic [1:0] {
    SGD_HOLD = 2'h0,
    SGD_OFFING = 2'h1,
    SGD_DEAD = 2'h3,
    SGD_ONING = 2'h2
  } sgd_state_t;

endpackage : sgd_pkg

// ### sgd_sequencer.sv
/*
  gate drive sequencer for three half-bridges with a classic wishbone
  register slave. holds per-bridge switching state machines, input
  deglitching, drain-source overcurrent deglitch with retry and fault pin.
  assumes analog comparators deliver gate and drain-source flags as
  asynchronous levels, and analog drivers take the select codes as levels.
*/
// How it works
// - seven gate current levels selected by a control field, codes above six clamp
// - chosen current flag during drive window, hold current after it ends
// - incoming gate waits until both gate-source monitors show off
// - fixed digital dead time follows feedback dead time before turn-on
// - strong pulldown on opposite gate throughout the drive window
// - a new command starts gate voltage watching with two monitors per bridge
// - gate voltage not at threshold at window end raises gate fault
// - new command ends an active window early, never stretching pwm
// - command inputs deglitched before they may change gate outputs
// - conducting gate always turned off before its complement turns on
// - drain-source over trip longer than deglitch flags overcurrent and retries
// - high monitors compare drain to switch, low compare switch to sense
// - trip level selectable by a seven level control field
// - charge pump and regulator undervoltage raise a fault
`timescale 1ns/1ps
module sgd_sequencer #(
  parameter int RETRY_CYCLES = sgd_pkg::RETRY_CYC
) (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst,
  // wishbone slave
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [3:0] i_wb_adr,
  input wire logic [3:0] i_wb_sel,
  input wire logic [31:0] i_wb_dat,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  // commands from pwm and commutation logic
  input wire logic [2:0] i_cmd_high,
  input wire logic [2:0] i_cmd_low,
  // analog monitors
  input wire logic [2:0] i_vgs_high_on,
  input wire logic [2:0] i_vgs_low_on,
  input wire logic [2:0] i_ocp_drain_switch,
  input wire logic [2:0] i_ocp_switch_sense,
  input wire logic i_cp_uv,
  input wire logic i_reg_uv,
  // gate drive
  output logic [2:0] o_high_gate_output,
  output logic [2:0] o_low_gate_output,
  output logic [2:0] o_high_gate_drive,
  output logic [2:0] o_low_gate_drive,
  output logic [2:0] o_high_strong_pulldown,
  output logic [2:0] o_low_strong_pulldown,
  output logic [2:0] o_gate_current_select,
  output logic [2:0] o_overcurrent_trip_level,
  // open-drain fault pin
  input wire logic i_fault_output_n,
  output logic o_fault_output_n,
  output logic o_fault_output_n_oe_n
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisers: three flops, change taken when stages two and three agree
  localparam int NIN = 21;
  logic [NIN-1:0] raw_in;
  logic [NIN-1:0] s1_q, s2_q, s3_q, stab_q;

  assign raw_in = {i_fault_output_n, i_reg_uv, i_cp_uv, i_ocp_switch_sense,
                   i_ocp_drain_switch, i_vgs_low_on, i_vgs_high_on, i_cmd_low, i_cmd_high};

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  generate
    for (genvar k = 0; k < NIN; k++) begin : g_stab
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          stab_q[k] <= 1'b0;
        end else if (s2_q[k] == s3_q[k]) begin
          stab_q[k] <= s3_q[k];
        end
      end
    end
  endgenerate

  logic [2:0] vgs_hi, vgs_lo, mon_hs, mon_ls;
  logic cp_uv, reg_uv, pin_level;
  assign vgs_hi = stab_q[8:6];
  assign vgs_lo = stab_q[11:9];
  assign mon_hs = stab_q[14:12];
  assign mon_ls = stab_q[17:15];
  assign cp_uv = stab_q[18];
  assign reg_uv = stab_q[19];
  assign pin_level = stab_q[NIN-1];

  ////////////////////////////////////////////////////////////////////////////
  // command deglitch: a change must persist before it reaches the bridges
  logic [5:0] cmd_q;
  logic [sgd_pkg::DEG_W-1:0] deg_cnt_q [6];

  generate
    for (genvar k = 0; k < 6; k++) begin : g_deg
      always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
          cmd_q[k] <= 1'b0;
          deg_cnt_q[k] <= '0;
        end else if (stab_q[k] == cmd_q[k]) begin
          deg_cnt_q[k] <= '0;
        end else if (deg_cnt_q[k] == sgd_pkg::IN_DEG_LIMIT) begin
          cmd_q[k] <= stab_q[k];
          deg_cnt_q[k] <= '0;
        end else begin
          deg_cnt_q[k] <= deg_cnt_q[k] + 1'b1;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [2:0] isel_q, trip_q;
  logic en_q, en_dly_q, ack_q;
  logic gdf_q, ocp_q;
  logic [2:0] gdf_hit;
  logic ocp_trip;
  logic [5:0] ocp_src_q;
  logic halt;
  logic wr_ctrl, wr_clear, req;

  assign req = i_wb_cyc && i_wb_stb && !ack_q;
  assign wr_ctrl = req && i_wb_we && i_wb_adr == sgd_pkg::ADDR_CTRL;
  assign wr_clear = req && i_wb_we && i_wb_adr == sgd_pkg::ADDR_CLEAR && i_wb_sel[0];

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req;
    end
  end
  assign o_wb_ack = ack_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      isel_q <= sgd_pkg::ISEL_RESET;
      trip_q <= sgd_pkg::TRIP_RESET;
      en_q <= sgd_pkg::EN_RESET;
    end else if (wr_ctrl) begin
      if (i_wb_sel[0]) begin
        isel_q <= i_wb_dat[sgd_pkg::CTRL_ISEL_LSB +: sgd_pkg::SEL_W];
        trip_q <= i_wb_dat[sgd_pkg::CTRL_TRIP_LSB +: sgd_pkg::SEL_W];
      end
      if (i_wb_sel[1]) begin
        en_q <= i_wb_dat[sgd_pkg::CTRL_EN_BIT];
      end
    end
  end

  // seven levels only, the unused top code clamps to the strongest
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_gate_current_select <= sgd_pkg::ISEL_RESET;
      o_overcurrent_trip_level <= sgd_pkg::TRIP_RESET;
    end else begin
      o_gate_current_select <= (isel_q > sgd_pkg::SEL_MAX) ? sgd_pkg::SEL_MAX : isel_q;
      o_overcurrent_trip_level <= (trip_q > sgd_pkg::SEL_MAX) ? sgd_pkg::SEL_MAX : trip_q;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_wb_dat <= '0;
    end else if (req && !i_wb_we) begin
      o_wb_dat <= '0;
      unique case (i_wb_adr)
        sgd_pkg::ADDR_CTRL: begin
          o_wb_dat[sgd_pkg::CTRL_ISEL_LSB +: sgd_pkg::SEL_W] <= isel_q;
          o_wb_dat[sgd_pkg::CTRL_TRIP_LSB +: sgd_pkg::SEL_W] <= trip_q;
          o_wb_dat[sgd_pkg::CTRL_EN_BIT] <= en_q;
        end
        sgd_pkg::ADDR_STATUS: begin
          o_wb_dat[sgd_pkg::ST_GDF_BIT] <= gdf_q;
          o_wb_dat[sgd_pkg::ST_OCP_BIT] <= ocp_q;
          o_wb_dat[sgd_pkg::ST_CPUV_BIT] <= cp_uv;
          o_wb_dat[sgd_pkg::ST_REGUV_BIT] <= reg_uv;
          o_wb_dat[sgd_pkg::ST_PIN_BIT] <= pin_level;
          o_wb_dat[sgd_pkg::ST_HI_LSB +: 3] <= o_high_gate_output;
          o_wb_dat[sgd_pkg::ST_LO_LSB +: 3] <= o_low_gate_output;
          o_wb_dat[sgd_pkg::ST_OCPSRC_LSB +: 6] <= ocp_src_q;
        end
        default: begin
          o_wb_dat <= '0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // faults: gate fault latched until cleared or enable pulse, set wins
  logic [sgd_pkg::RETRY_W-1:0] retry_q;
  logic en_rise;
  assign en_rise = en_q && !en_dly_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      en_dly_q <= 1'b0;
      gdf_q <= 1'b0;
    end else begin
      en_dly_q <= en_q;
      gdf_q <= (|gdf_hit) || (gdf_q && !wr_clear_gdf() && !en_rise);
    end
  end

  function automatic logic wr_clear_gdf();
    return wr_clear && i_wb_dat[sgd_pkg::CLR_GDF_BIT];
  endfunction : wr_clear_gdf

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ocp_q <= 1'b0;
      retry_q <= '0;
    end else if (ocp_trip) begin
      ocp_q <= 1'b1;
      retry_q <= sgd_pkg::RETRY_W'(RETRY_CYCLES);
    end else if (ocp_q) begin
      if (retry_q == '0) begin
        ocp_q <= 1'b0;
      end else begin
        retry_q <= retry_q - 1'b1;
      end
    end
  end

  assign halt = gdf_q || ocp_q || cp_uv || reg_uv || !en_q;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_fault_output_n_oe_n <= 1'b1;
    end else begin
      o_fault_output_n_oe_n <= !(gdf_q || ocp_q || cp_uv || reg_uv);
    end
  end
  assign o_fault_output_n = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // drain-source overcurrent deglitch, one counter per monitor
  logic [5:0] mon_all, gate_on, ocp_hit;
  logic [sgd_pkg::WIN_W-1:0] ocp_cnt_q [6];
  // high monitors see drain vs switch, low monitors switch vs sense
  assign mon_all = {mon_ls, mon_hs};
  assign gate_on = {o_low_gate_output, o_high_gate_output};

  generate
    for (genvar m = 0; m < 6; m++) begin : g_ocp
      always_ff @(posedge i_ref_clk) begin
        if (i_rst || !(mon_all[m] && gate_on[m])) begin
          ocp_cnt_q[m] <= '0;
        end else if (ocp_cnt_q[m] != sgd_pkg::OCP_LIMIT) begin
          ocp_cnt_q[m] <= ocp_cnt_q[m] + 1'b1;
        end
      end
      assign ocp_hit[m] = ocp_cnt_q[m] == sgd_pkg::OCP_LIMIT;
    end
  endgenerate
  assign ocp_trip = |ocp_hit;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      ocp_src_q <= '0;
    end else if (ocp_trip) begin
      ocp_src_q <= ocp_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per half-bridge switching sequencer
  generate
    for (genvar b = 0; b < 3; b++) begin : g_br
      sgd_pkg::sgd_state_t st_q;
      logic hi_q, lo_q, side_hi_q, hit_q;
      logic [sgd_pkg::WIN_W-1:0] win_q, dead_q;
      logic tgt_hi, tgt_lo, changed;

      // both commands high is taken as both off
      assign tgt_hi = cmd_q[b] && !cmd_q[b+3];
      assign tgt_lo = cmd_q[b+3] && !cmd_q[b];
      assign changed = (hi_q != tgt_hi) || (lo_q != tgt_lo);

      always_ff @(posedge i_ref_clk) begin
        if (i_rst || halt) begin
          st_q <= sgd_pkg::SGD_HOLD;
          hi_q <= 1'b0;
          lo_q <= 1'b0;
          side_hi_q <= 1'b0;
          win_q <= '0;
          dead_q <= '0;
          hit_q <= 1'b0;
        end else begin
          hit_q <= 1'b0;
          unique case (st_q)
            sgd_pkg::SGD_HOLD: begin
              if (changed) begin
                side_hi_q <= hi_q;
                hi_q <= 1'b0;
                lo_q <= 1'b0;
                win_q <= sgd_pkg::WIN_LOAD;
                st_q <= sgd_pkg::SGD_OFFING;
              end
            end
            sgd_pkg::SGD_OFFING: begin
              if (!vgs_hi[b] && !vgs_lo[b]) begin
                dead_q <= sgd_pkg::DEAD_LOAD;
                st_q <= sgd_pkg::SGD_DEAD;
              end else if (win_q == sgd_pkg::WIN_ONE) begin
                hit_q <= 1'b1;
              end else begin
                win_q <= win_q - 1'b1;
              end
            end
            sgd_pkg::SGD_DEAD: begin
              win_q <= '0;
              if (dead_q > sgd_pkg::WIN_ONE) begin
                dead_q <= dead_q - 1'b1;
              end else if (tgt_hi || tgt_lo) begin
                hi_q <= tgt_hi;
                lo_q <= tgt_lo;
                side_hi_q <= tgt_hi;
                win_q <= sgd_pkg::WIN_LOAD;
                st_q <= sgd_pkg::SGD_ONING;
              end else begin
                st_q <= sgd_pkg::SGD_HOLD;
              end
            end
            sgd_pkg::SGD_ONING: begin
              if (changed) begin
                hi_q <= 1'b0;
                lo_q <= 1'b0;
                win_q <= sgd_pkg::WIN_LOAD;
                st_q <= sgd_pkg::SGD_OFFING;
              end else if (win_q == sgd_pkg::WIN_ONE) begin
                hit_q <= side_hi_q ? !vgs_hi[b] : !vgs_lo[b];
                win_q <= '0;
                st_q <= sgd_pkg::SGD_HOLD;
              end else begin
                win_q <= win_q - 1'b1;
              end
            end
          endcase
        end
      end

      assign gdf_hit[b] = hit_q;
      assign o_high_gate_output[b] = hi_q;
      assign o_low_gate_output[b] = lo_q;
      // full current only while the window runs, hold current otherwise
      assign o_high_gate_drive[b] = (win_q != '0) && side_hi_q;
      assign o_low_gate_drive[b] = (win_q != '0) && !side_hi_q;
      assign o_low_strong_pulldown[b] = (win_q != '0) && side_hi_q;
      assign o_high_strong_pulldown[b] = (win_q != '0) && !side_hi_q;
    end
  endgenerate

endmodule : sgd_sequencer

// ### sgd_assertions.sv
/* concurrent checks on the sgd_sequencer ports.
   assumes it is bound to every sgd_sequencer instance. */
`timescale 1ns/1ps
module sgd_checker #(
  parameter int RETRY_CYCLES = 20
) (
  // clock, reset and bus
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic o_wb_ack,
  // monitors
  input wire logic [2:0] i_vgs_low_on,
  input wire logic [2:0] i_ocp_switch_sense,
  input wire logic i_cp_uv,
  // gate drive
  input wire logic [2:0] o_high_gate_output,
  input wire logic [2:0] o_low_gate_output,
  input wire logic [2:0] o_high_gate_drive,
  input wire logic [2:0] o_low_gate_drive,
  input wire logic [2:0] o_high_strong_pulldown,
  input wire logic [2:0] o_low_strong_pulldown,
  input wire logic [2:0] o_gate_current_select,
  input wire logic [2:0] o_overcurrent_trip_level,
  input wire logic o_fault_output_n_oe_n
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_rst);
  int drv_cnt;
  int ocp_cnt;
  ////////////////////////////////////////
  // run lengths on bridge 0
  always_ff @(posedge i_ref_clk) begin
    drv_cnt <= (o_high_gate_drive[0] && !i_rst) ? drv_cnt + 1 : 0;
  end
  always_ff @(posedge i_ref_clk) begin
    ocp_cnt <= (i_ocp_switch_sense[0] && o_low_gate_output[0] && !i_rst) ? ocp_cnt + 1 : 0;
  end
  ////////////////////////////////////////
  a_no_shoot_through: assert property ((o_high_gate_output & o_low_gate_output) == 3'h0)
    else $error("both gates of a bridge on");
  a_ack_follows_take: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("bus request not answered next cycle");
  a_ack_single: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  a_pulldown_pairs: assert property ((o_low_strong_pulldown == o_high_gate_drive) &&
    (o_high_strong_pulldown == o_low_gate_drive)) else $error("pulldown not paired with drive");
  a_window_bound: assert property (drv_cnt <= 80)
    else $error("drive current held past window");
  a_dead_gap: assert property ($rose(o_high_gate_output[0]) |-> !$past(o_low_gate_output[0], 3))
    else $error("dead time too short");
  a_vgs_handshake: assert property ($rose(o_high_gate_output[0]) |-> !$past(i_vgs_low_on[0], 3))
    else $error("turn-on while complement still on");
  a_fault_gates_off: assert property (!o_fault_output_n_oe_n && $past(!o_fault_output_n_oe_n)
    |-> (o_high_gate_output | o_low_gate_output) == 3'h0) else $error("gate on during fault");
  a_ocp_deglitch: assert property (ocp_cnt <= 88)
    else $error("overcurrent not acted on");
  a_uv_reported: assert property (i_cp_uv [*8] |-> !o_fault_output_n_oe_n)
    else $error("undervoltage not reported");
  a_select_range: assert property (o_gate_current_select <= 3'h6 &&
    o_overcurrent_trip_level <= 3'h6) else $error("select code above six");
endmodule : sgd_checker

bind sgd_sequencer sgd_checker #(.RETRY_CYCLES(RETRY_CYCLES)) u_sgd_chk (.*);

// ### sgd_fet_model.sv
/* behavioural external mosfets: gate-source monitors follow the gates
   after a charge delay. assumes gate outputs of sgd_sequencer. */
`timescale 1ns/1ps
module sgd_fet_model (
  // clock
  input wire logic i_ref_clk,
  // gates and test controls
  input wire logic [2:0] i_high_gate,
  input wire logic [2:0] i_low_gate,
  input wire logic [2:0] i_stuck_off,
  input wire logic i_slow,
  // gate-source monitors
  output logic [2:0] o_vgs_high_on,
  output logic [2:0] o_vgs_low_on
);
  int dly;
  int hc [3];
  int lc [3];
  // charge time kept inside the drive window
  assign dly = i_slow ? 40 : 6;
  always_ff @(posedge i_ref_clk) begin
    for (int b = 0; b < 3; b++) begin
      hc[b] <= i_high_gate[b] ? ((hc[b] < dly) ? hc[b] + 1 : dly) : ((hc[b] > 0) ? hc[b] - 1 : 0);
      lc[b] <= i_low_gate[b] ? ((lc[b] < dly) ? lc[b] + 1 : dly) : ((lc[b] > 0) ? lc[b] - 1 : 0);
    end
  end
  always_comb begin
    for (int b = 0; b < 3; b++) begin
      o_vgs_high_on[b] = !i_stuck_off[b] && (hc[b] * 2 > dly);
      o_vgs_low_on[b] = lc[b] * 2 > dly;
    end
  end
endmodule : sgd_fet_model

// ### sgd_tb.sv
/* self-checking bench for sgd_sequencer with mosfet model.
   assumes sgd_pkg, the checker and the model compiled first. */
`timescale 1ns/1ps
module testbench;
  typedef struct packed {logic [8:0] w; logic [2:0] s; logic [2:0] t;} sgd_row_t;
  sgd_row_t rows [8] = '{'{9'h100, 3'h0, 3'h0}, '{9'h161, 3'h1, 3'h6}, '{9'h152, 3'h2, 3'h5},
    '{9'h143, 3'h3, 3'h4}, '{9'h134, 3'h4, 3'h3}, '{9'h125, 3'h5, 3'h2},
    '{9'h116, 3'h6, 3'h1}, '{9'h177, 3'h6, 3'h6}};
  logic clk = 0, rst = 1, cyc = 0, stb = 0, we = 0, slow = 0, cpuv = 0, reguv = 0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0, q;
  logic [2:0] ch = 3'h0, cl = 3'h0, stuck = 3'h0, ocpl = 3'h0;
  wire [31:0] rdat;
  wire [2:0] vh, vl, hg, lg, hd, ld, hp, lp, isel, trip;
  wire ack, oen;
  int err_count = 0, cmp_count = 0, cyc_n = 0, n, b;
  always #25 clk = ~clk;
  sgd_sequencer #(.RETRY_CYCLES(20)) DUT (.i_ref_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hf), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_cmd_high(ch), .i_cmd_low(cl), .i_vgs_high_on(vh),
    .i_vgs_low_on(vl), .i_ocp_drain_switch(3'h0), .i_ocp_switch_sense(ocpl),
    .i_cp_uv(cpuv), .i_reg_uv(reguv), .o_high_gate_output(hg), .o_low_gate_output(lg),
    .o_high_gate_drive(hd), .o_low_gate_drive(ld), .o_high_strong_pulldown(hp),
    .o_low_strong_pulldown(lp), .o_gate_current_select(isel),
    .o_overcurrent_trip_level(trip), .i_fault_output_n(oen), .o_fault_output_n(),
    .o_fault_output_n_oe_n(oen));
  sgd_fet_model FET (.i_ref_clk(clk), .i_high_gate(hg), .i_low_gate(lg),
    .i_stuck_off(stuck), .i_slow(slow), .o_vgs_high_on(vh), .o_vgs_low_on(vl));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    {cyc, stb, we, adr, wdat} <= {2'h3, w, a, d};
    do
      @(posedge clk);
    while (ack !== 1'b1);
    q = rdat;
    {cyc, stb} <= 2'h0;
  endtask : wb
  task automatic swing(input int s, input logic hi);
    @(posedge clk);
    ch[s] <= hi;
    cl[s] <= !hi;
    for (n = 0; n < 300 && (hi ? hg[s] : lg[s]) !== 1'b1; n++) @(posedge clk);
    chk("drive", 32'(hi ? {hd[s], lp[s]} : {ld[s], hp[s]}), 32'h3);
    chk("opposite", 32'(hi ? lg[s] : hg[s]), 32'h0);
    repeat (82) @(posedge clk);
    chk("hold", 32'({hd[s], ld[s], hp[s], lp[s], ~oen}), 32'h0);
  endtask : swing
  ////////////////////////////////////////
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (cyc_n == 20000) begin
      err_count++;
      complete_run();
    end
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 0;
    ch[0] <= 1;
    repeat (20) @(posedge clk);
    chk("idle", 32'({hg, lg, hd, ld, oen}), 32'h1);
    ch[0] <= 0;
    wb(0, sgd_pkg::ADDR_CTRL, 0);
    chk("ctrl reset", q, 0);
    foreach (rows[i]) begin
      wb(1, sgd_pkg::ADDR_CTRL, 32'(rows[i].w));
      wb(0, sgd_pkg::ADDR_CTRL, 0);
      if (rows[i].w[2:0] != 3'h7)
        chk("ctrl", q, 32'(rows[i].w));
      chk("select", 32'({isel, trip}), 32'({rows[i].s, rows[i].t}));
    end
    wb(1, 4'hc, 32'hffffffff);
    wb(0, 4'hc, 0);
    chk("unmapped", q, 0);
    for (b = 0; b < 3; b++) begin
      slow <= (b == 2);
      swing(b, 1);
      swing(b, 0);
    end
    // abort an active window on bridge 1
    ch[1] <= 1;
    cl[1] <= 0;
    for (n = 0; n < 300 && hg[1] !== 1'b1; n++) @(posedge clk);
    repeat (10) @(posedge clk);
    {ch[1], cl[1]} <= 2'h1;
    for (n = 0; n < 80 && hg[1] !== 1'b0; n++) @(posedge clk);
    chk("abort", 32'(n < 20), 32'h1);
    // short command pulse on bridge 2
    {ch[2], cl[2]} <= 2'h2;
    repeat (3) @(posedge clk);
    {ch[2], cl[2]} <= 2'h1;
    n = 0;
    repeat (20) begin
      @(posedge clk);
      if (lg[2] !== 1'b1)
        n++;
    end
    chk("glitch", n, 0);
    // gate never reaches threshold
    stuck[0] <= 1;
    {ch[0], cl[0]} <= 2'h2;
    repeat (130) @(posedge clk);
    wb(0, sgd_pkg::ADDR_STATUS, 0);
    chk("gate fault", q & 32'h1f, 32'h1);
    chk("fault off", 32'({hg, lg, oen}), 0);
    stuck[0] <= 0;
    ch[0] <= 0;
    wb(1, sgd_pkg::ADDR_CLEAR, 32'h1);
    repeat (10) @(posedge clk);
    wb(0, sgd_pkg::ADDR_STATUS, 0);
    chk("cleared", q & 32'h1f, 32'h10);
    swing(0, 0);
    // overcurrent shorter, then longer than the deglitch
    ocpl[0] <= 1;
    repeat (30) @(posedge clk);
    ocpl[0] <= 0;
    repeat (5) @(posedge clk);
    chk("ocp short", 32'(oen), 32'h1);
    ocpl[0] <= 1;
    repeat (100) @(posedge clk);
    ocpl[0] <= 0;
    wb(0, sgd_pkg::ADDR_STATUS, 0);
    chk("ocp", q & 32'h3f001f, 32'h80002);
    repeat (40) @(posedge clk);
    wb(0, sgd_pkg::ADDR_STATUS, 0);
    chk("retry", q & 32'h12, 32'h10);
    for (b = 0; b < 2; b++) begin
      {reguv, cpuv} <= 2'(1 << b);
      repeat (12) @(posedge clk);
      wb(0, sgd_pkg::ADDR_STATUS, 0);
      chk("uv", q & 32'h1f, 32'(4 << b));
      {reguv, cpuv} <= 2'h0;
      repeat (10) @(posedge clk);
      wb(0, sgd_pkg::ADDR_STATUS, 0);
      chk("uv gone", q & 32'h1f, 32'h10);
    end
    @(posedge clk);
    rst <= 1;
    repeat (2) @(posedge clk);
    rst <= 0;
    wb(0, sgd_pkg::ADDR_CTRL, 0);
    chk("ctrl reset2", q, 0);
    chk("gates reset2", 32'({hg, lg}), 0);
    complete_run();
  end
endmodule : testbench
